// File: rtl/dio_map.svh
// constants of the dense i/o switch configuration block: offsets, fields, resets, times
// assumes: included by bare name from the package and dio_top; definitions only
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DIO_OFS_CFG      8'h00
`define DIO_OFS_OUTWORD  8'h04
`define DIO_OFS_INWORD   8'h08
`define DIO_OFS_STATUS   8'h0C

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define DIO_CFG_BITS     10
`define DIO_CFG_RESET    10'h000
`define DIO_OUT_RESET    32'h0000_0000
`define DIO_PULSE_LO     24
`define DIO_PULSE_HI     31
`define DIO_MIX_IN_LO    16

// ------------------------------------------------------------
// timing: clock rate, times in microseconds
// ------------------------------------------------------------
`define DIO_CLK_KHZ      40000
`define DIO_RESP_SHORT_US 2500
`define DIO_RESP_LONG_US 15000
`define DIO_PW_SHORT_US  1000
`define DIO_PW_LONG_US   4000
// longest times round down, least times round up
`define DIO_MAX_CYC(us)  (((us) * `DIO_CLK_KHZ) / 1000)
`define DIO_MIN_CYC(us)  ((((us) * `DIO_CLK_KHZ) + 999) / 1000)

`endif

// File: rtl/dio_pkg.sv
// types of the dense i/o switch configuration block
// assumes: dio_map.svh sits beside it
`include "dio_map.svh"

package dio_pkg;

    // ------------------------------------------------------------
    // unit kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIO_KIND_IN,     // 32 inputs
        DIO_KIND_OUT,    // 32 outputs
        DIO_KIND_MIX,    // 16 outputs plus 16 inputs
        DIO_KIND_NONE    // spare code, behaves as input unit without inputs
    } dio_kind_t;

    // switch settings as held in the configuration register
    typedef struct packed {
        dio_kind_t  kind;      // unit kind
        logic [2:0] spare;     // switch positions 6 to 8, no function
        logic       pos_logic; // dynamic output polarity
        logic       resp_long; // normal input response time selection
        logic       width_long;// pulse width selection
        logic       pulse_en;  // pulse capture selection
        logic       dyn;       // operation mode switch
    } dio_cfg_t;

endpackage

// File: rtl/dio_filter.sv
// one input filter: the output follows the raw input once it has differed for a given count
// assumes: raw input synchronous to the clock; limit at least one
`timescale 1ns/1ps
`default_nettype none

module dio_filter (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_raw,   // field level
    input  wire logic [19:0] i_limit, // cycles the level must differ
    output logic             o_level  // filtered level
);

    logic [19:0] cnt_q;   // cycles of disagreement so far
    logic [19:0] cnt_d;
    logic        lvl_q;   // accepted level
    logic        lvl_d;

    // ------------------------------------------------------------
    // next state: any return to the accepted level restarts the count
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = 20'h00000;
        lvl_d = lvl_q;
        if (i_raw != lvl_q) begin
            if (cnt_q + 20'h00001 >= i_limit) begin
                lvl_d = i_raw;           // held long enough
            end else begin
                cnt_d = cnt_q + 20'h00001;
            end
        end
    end

    // registers only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 20'h00000;
            lvl_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;

endmodule

`default_nettype wire

// File: rtl/dio_top.sv
// dense i/o unit: switch settings, static i/o words, input filters and pulse capture over apb
// assumes: field inputs synchronous to i_mclk; apb master keeps the request until pready
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.svh"

module dio_top
    import dio_pkg::*;
#(
    parameter int RESP_SHORT_CYC = `DIO_MAX_CYC(`DIO_RESP_SHORT_US),
    parameter int RESP_LONG_CYC  = `DIO_MAX_CYC(`DIO_RESP_LONG_US),
    parameter int PW_SHORT_CYC   = `DIO_MIN_CYC(`DIO_PW_SHORT_US),
    parameter int PW_LONG_CYC    = `DIO_MIN_CYC(`DIO_PW_LONG_US)
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [31:0] i_field_in,  // 15:0 first connector, 31:16 second_connector
    output logic [31:0]      o_field_out, // output terminals
    output logic             o_dyn_mode   // dynamic operation active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dio_cfg_t    cfg_q,     cfg_d;      // switch settings
    logic [31:0] outword_q, outword_d;  // output word from the controller
    logic [31:0] latch_q,   latch_d;    // captured pulses
    logic [31:0] fout_q,    fout_d;     // driven field outputs
    logic [31:0] rdata_q,   rdata_d;
    logic        ready_q,   ready_d;
    logic        err_q,     err_d;
    logic        dyn_q,     dyn_d;
    logic [31:0] filt;                  // filter outputs, one per input
    logic [31:0] in_mask;               // inputs that exist in the current mode
    logic [31:0] pulse_mask;            // inputs acting as pulse capture
    logic [31:0] in_view;               // input word as read
    logic [19:0] lim_norm;              // normal response count
    logic [19:0] lim_pulse;             // pulse width count
    logic        dyn_eff;
    logic        pulse_act;
    logic        acc_done;              // apb transfer completes this edge
    logic        rd_in_clr;             // input word read completes

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, `DIO_OFS_CFG) | hit(a, `DIO_OFS_OUTWORD) |
                 hit(a, `DIO_OFS_INWORD) | hit(a, `DIO_OFS_STATUS);
    endfunction

    // ------------------------------------------------------------
    // effective modes from the switches
    // ------------------------------------------------------------
    always_comb begin
        // dynamic operation exists only for output and mixed units
        dyn_eff   = cfg_q.dyn & ((cfg_q.kind == DIO_KIND_OUT) | (cfg_q.kind == DIO_KIND_MIX));
        // the mixed unit drops pulse capture once dynamic
        pulse_act = cfg_q.pulse_en & ((cfg_q.kind == DIO_KIND_IN) |
                    ((cfg_q.kind == DIO_KIND_MIX) & ~dyn_eff));
        pulse_mask = 32'h0000_0000;
        if (pulse_act) begin
            pulse_mask[`DIO_PULSE_HI:`DIO_PULSE_LO] = 8'hFF;
        end
        case (cfg_q.kind)
            DIO_KIND_IN:  in_mask = 32'hFFFF_FFFF;
            DIO_KIND_MIX: in_mask = dyn_eff ? 32'h0000_0000 : 32'hFFFF_0000;
            default:      in_mask = 32'h0000_0000;
        endcase
        lim_norm  = cfg_q.resp_long ? RESP_LONG_CYC[19:0] : RESP_SHORT_CYC[19:0];
        // width switch only matters where pulse inputs exist
        lim_pulse = (pulse_act & cfg_q.width_long) ? PW_LONG_CYC[19:0] : PW_SHORT_CYC[19:0];
    end

    // ------------------------------------------------------------
    // input filters: pulse lanes take the width count, the rest the response count
    // ------------------------------------------------------------
    for (genvar g = 0; g < 32; g++) begin : g_in
        dio_filter u_filt (
            .i_mclk  (i_mclk),
            .i_rst   (i_rst),
            .i_raw   (i_field_in[g]),
            .i_limit (pulse_mask[g] ? lim_pulse : lim_norm),
            .o_level (filt[g])
        );
    end

    // pulse lanes show the latch as well as the present level
    assign in_view = (filt | (latch_q & pulse_mask)) & in_mask;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign acc_done  = i_psel & i_penable & ready_q;
    assign rd_in_clr = acc_done & ~i_pwrite & hit(i_paddr, `DIO_OFS_INWORD);

    // ------------------------------------------------------------
    // next values: registers, pulse latches, bus answer, outputs
    // ------------------------------------------------------------
    always_comb begin
        cfg_d     = cfg_q;
        outword_d = outword_q;
        // a read clears the latch, but a pulse seen now is kept: set wins
        latch_d   = (rd_in_clr ? 32'h0000_0000 : latch_q) | (filt & pulse_mask);
        if (!pulse_act) begin
            latch_d = 32'h0000_0000;
        end
        // one wait state, then ready for a single cycle
        ready_d = i_psel & i_penable & ~ready_q;
        err_d   = 1'b0;
        rdata_d = 32'h0000_0000;
        if (ready_d) begin
            err_d = ~mapped(i_paddr);
            if (!i_pwrite) begin
                if (hit(i_paddr, `DIO_OFS_CFG)) begin
                    rdata_d = {22'h000000, cfg_q};
                end else if (hit(i_paddr, `DIO_OFS_OUTWORD)) begin
                    rdata_d = outword_q;
                end else if (hit(i_paddr, `DIO_OFS_INWORD)) begin
                    rdata_d = in_view;
                end else if (hit(i_paddr, `DIO_OFS_STATUS)) begin
                    rdata_d = {29'h00000000, cfg_q.resp_long, pulse_act, dyn_eff};
                end
            end
        end
        // writes land on the edge where pready is sampled high
        if (acc_done && i_pwrite) begin
            if (hit(i_paddr, `DIO_OFS_CFG)) begin
                cfg_d = dio_cfg_t'(i_pwdata[`DIO_CFG_BITS-1:0]);
            end else if (hit(i_paddr, `DIO_OFS_OUTWORD)) begin
                outword_d = i_pwdata;
            end
        end
        // output terminals per unit kind and mode
        case (cfg_q.kind)
            DIO_KIND_OUT: begin
                if (dyn_eff) begin
                    // negative logic drives the inverted word
                    fout_d = cfg_q.pos_logic ? outword_q : ~outword_q;
                end else begin
                    fout_d = outword_q;
                end
            end
            DIO_KIND_MIX: begin
                // dynamic mixed masks all inputs and drives no outputs; polarity ignored
                fout_d = dyn_eff ? 32'h0000_0000 : {16'h0000, outword_q[15:0]};
            end
            default: begin
                fout_d = 32'h0000_0000;
            end
        endcase
        dyn_d = dyn_eff;
    end

    // ------------------------------------------------------------
    // registers only
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cfg_q     <= dio_cfg_t'(`DIO_CFG_RESET);
            outword_q <= `DIO_OUT_RESET;
            latch_q   <= 32'h0000_0000;
            fout_q    <= 32'h0000_0000;
            rdata_q   <= 32'h0000_0000;
            ready_q   <= 1'b0;
            err_q     <= 1'b0;
            dyn_q     <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            outword_q <= outword_d;
            latch_q   <= latch_d;
            fout_q    <= fout_d;
            rdata_q   <= rdata_d;
            ready_q   <= ready_d;
            err_q     <= err_d;
            dyn_q     <= dyn_d;
        end
    end

    assign o_prdata    = rdata_q;
    assign o_pready    = ready_q;
    assign o_pslverr   = err_q;
    assign o_field_out = fout_q;
    assign o_dyn_mode  = dyn_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    dyn_out_neg_a: assert property ((cfg_q.kind == DIO_KIND_OUT) && cfg_q.dyn && !cfg_q.pos_logic && $stable(cfg_q)
        |=> o_field_out == ~$past(outword_q)) else $error("negative logic output wrong");
    mix_upper_off_a: assert property ((cfg_q.kind == DIO_KIND_MIX) && $stable(cfg_q)
        |=> o_field_out[31:16] == 16'h0000) else $error("mixed unit drives upper outputs");
    mix_dyn_nopulse_a: assert property ((cfg_q.kind == DIO_KIND_MIX) && cfg_q.dyn |-> !pulse_act)
        else $error("pulse capture active in dynamic mode");
    pulse_lanes_a: assert property (pulse_mask[23:0] == 24'h000000)
        else $error("pulse capture outside second connector 08-15");
    latch_empty_a: assert property (!pulse_act |=> latch_q == 32'h0000_0000)
        else $error("latch kept without pulse capture");
    resp_count_a: assert property (lim_norm == (cfg_q.resp_long ? RESP_LONG_CYC[19:0] : RESP_SHORT_CYC[19:0]))
        else $error("normal response count wrong");
    width_count_a: assert property (pulse_act && cfg_q.width_long |-> lim_pulse == PW_LONG_CYC[19:0])
        else $error("pulse width count wrong");
    latch_hold_a: assert property (latch_q[`DIO_PULSE_HI] && !rd_in_clr && pulse_act && $stable(cfg_q)
        |=> latch_q[`DIO_PULSE_HI]) else $error("pulse latch lost before read");
    in_unit_quiet_a: assert property ((cfg_q.kind == DIO_KIND_IN) [*2] |-> o_field_out == 32'h0000_0000)
        else $error("input unit drives outputs");
    apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
        else $error("apb answer timing wrong");

    dyn_out_c: cover property ((cfg_q.kind == DIO_KIND_OUT) && o_dyn_mode);
    pulse_seen_c: cover property (pulse_act && latch_q[`DIO_PULSE_LO]);
    read_clear_c: cover property (rd_in_clr && latch_q != 32'h0000_0000);

endmodule

`default_nettype wire

// File: dv/dio_field_model.sv
// field side model: sensors on both connectors, steady levels plus timed pulses
// assumes: the bench sets levels and starts pulses just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module dio_field_model (
    input  wire logic        i_mclk,
    input  wire logic [31:0] i_level,      // steady sensor levels
    input  wire logic        i_pulse_go,   // start one pulse
    input  wire logic [4:0]  i_pulse_lane, // lane that pulses
    input  wire logic [7:0]  i_pulse_len,  // pulse length in cycles
    output logic [31:0]      o_field       // lines into the unit
);
    logic [7:0] left_q = 8'h00; // cycles of pulse still to run
    logic [4:0] lane_q = 5'h00; // lane of the running pulse

    // pulse timer: a sensor contact closes for an exact count of cycles
    always_ff @(posedge i_mclk) begin
        if (i_pulse_go) begin
            left_q <= i_pulse_len;
            lane_q <= i_pulse_lane;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end

    // a pulse inverts the steady level, so it shows whatever the lane rests at
    assign o_field = i_level ^ ((left_q != 8'h00) ? (32'h0000_0001 << lane_q) : 32'h0000_0000);
endmodule
`default_nettype wire

// File: dv/tb_dense_io_switch_config.sv
// self-checking bench: apb master, switch setting table, filter timing and pulse capture
// assumes: design built with short filter counts; field model drives the inputs
`timescale 1ns/1ps
`default_nettype none

module tb_dense_io_switch_config;
    import dio_pkg::*;
    // ------------------------------------------------------------
    // short counts keep the run small
    // ------------------------------------------------------------
    localparam int RS = 5;
    localparam int RL = 20;
    typedef struct packed { logic [31:0] cfg; logic [31:0] fout; logic [31:0] inw; logic [31:0] stat; } dio_row_t;
    typedef struct packed { logic [31:0] cfg; logic [4:0] lane; logic [7:0] len; logic [31:0] exp; } dio_pulse_t;
    logic        clk = 1'b0;      // 40 MHz clock
    logic        rst = 1'b1;      // async reset
    logic        psel = 1'b0;     // apb select
    logic        penable = 1'b0;  // apb enable
    logic        pwrite = 1'b0;   // apb direction
    logic [7:0]  paddr = 8'h00;   // apb address
    logic [31:0] pwdata = 32'h0;  // apb write data
    logic [31:0] prdata;          // apb read data
    logic        pready;          // apb ready
    logic        pslverr;         // apb error
    logic [31:0] field_in;        // lines from the model
    logic [31:0] field_out;       // output terminals
    logic        dyn_mode;        // dynamic mode flag
    logic [31:0] level = 32'h0;   // steady field levels
    logic        go = 1'b0;       // pulse start
    logic [4:0]  lane = 5'h00;    // pulse lane
    logic [7:0]  len = 8'h00;     // pulse length
    logic [31:0] rd;              // last read data
    logic        er;              // last error flag
    int          errors = 0;      // mismatches
    int          total_checks = 0;// comparisons
    int          cycles = 0;      // timeout count
    // kind[9:8] resp[3] width[2] pulse[1] dyn[0]; outword is 12345678 on every row
    dio_row_t rows [11] = '{
        '{32'h000, 32'h0,        32'hA5A55A5A, 32'h0}, '{32'h100, 32'h12345678, 32'h0, 32'h0},
        '{32'h101, 32'hEDCBA987, 32'h0,        32'h1}, '{32'h111, 32'h12345678, 32'h0, 32'h1},
        '{32'h1F0, 32'h12345678, 32'h0,        32'h0}, '{32'h200, 32'h00005678, 32'hA5A50000, 32'h0},
        '{32'h203, 32'h0,        32'h0,        32'h1}, '{32'h202, 32'h00005678, 32'hA5A50000, 32'h2},
        '{32'h0FE, 32'h0,        32'hA5A55A5A, 32'h6}, '{32'h001, 32'h0,        32'hA5A55A5A, 32'h0},
        '{32'h300, 32'h0,        32'h0,        32'h0}};
    // pulses near the minimum width on capture and normal lanes
    dio_pulse_t prow [8] = '{
        '{32'h002, 5'd24, 8'd4, 32'h01000000}, '{32'h002, 5'd31, 8'd2, 32'h0},
        '{32'h006, 5'd28, 8'd9, 32'h10000000}, '{32'h006, 5'd28, 8'd6, 32'h0},
        '{32'h002, 5'd23, 8'd9, 32'h0},        '{32'h202, 5'd24, 8'd4, 32'h01000000},
        '{32'h000, 5'd24, 8'd4, 32'h0},        '{32'h203, 5'd24, 8'd9, 32'h0}};

    always #12.5 clk = ~clk;

    dio_top #(.RESP_SHORT_CYC(RS), .RESP_LONG_CYC(RL), .PW_SHORT_CYC(3), .PW_LONG_CYC(8)) dut_u (
        .i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_field_in(field_in), .o_field_out(field_out), .o_dyn_mode(dyn_mode));

    dio_field_model field_u (
        .i_mclk(clk), .i_level(level), .i_pulse_go(go), .i_pulse_lane(lane), .i_pulse_len(len),
        .o_field(field_in));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; pready and the answer are taken at the rising edge that completes it,
    // the design's registers still show their pre-edge values there; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        chk(field_out, 32'h0000_0000);
        chk({30'h0, dyn_mode, pready}, 32'h0);
        chk({prdata[30:0], pslverr}, 32'h0);
        rst <= 1'b0;
        level <= 32'hA5A55A5A;
        // switch setting table
        for (int k = 0; k < 11; k++) begin
            apb(1'b1, 8'h00, rows[k].cfg);
            apb(1'b1, 8'h04, 32'h12345678);
            repeat (30) @(posedge clk);
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, rows[k].cfg);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, rows[k].inw);
            apb(1'b0, 8'h0C, 32'h0);
            chk(rd, rows[k].stat);
            chk(field_out, rows[k].fout);
            chk({31'h0, dyn_mode}, {31'h0, rows[k].stat[0]});
        end
        // unmapped and read-only places
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h300);
        apb(1'b1, 8'h00, 32'hFFFFFFFF);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3FF);
        // normal response time, short then long
        for (int k = 0; k < 2; k++) begin
            level <= 32'h0;
            apb(1'b1, 8'h00, (k == 0) ? 32'h000 : 32'h008);
            repeat (30) @(posedge clk);
            level <= 32'h00010001;
            repeat ((k == 0) ? 0 : 8) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'h0);
            repeat ((k == 0) ? RS + 4 : RL + 4) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'h00010001);
        end
        // pulse capture: width limits, lanes, hold until read
        level <= 32'h0;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 8'h00, prow[k].cfg);
            repeat (30) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0);
            @(posedge clk);
            go <= 1'b1;
            lane <= prow[k].lane;
            len <= prow[k].len;
            @(posedge clk);
            go <= 1'b0;
            repeat (25) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, prow[k].exp);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'h0);
        end
        // reset in mid-run clears the settings
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, dyn_mode}, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        chk(field_out, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
